// file: clock_source_pll_config_params.svh
// register map, field positions, reset values and counts of the clock source configuration
// assumes inclusion by bare name from the package, the design file and the checker
`ifndef CLOCK_SOURCE_PLL_CONFIG_PARAMS_SVH
`define CLOCK_SOURCE_PLL_CONFIG_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_PLL_POWER_POLARITY 12'h010
`define IDX_VCO_CALIBRATION    12'h018
`define IDX_VCO_DIVIDER        12'h1e0
`define IDX_DIST_SOURCE        12'h1e1
`define IDX_STAGED_UPDATE      12'h232
`define IDX_CONFIG_STATUS      12'h233

`define ADDR_W                 14

// field positions
`define PLL_POWER_HI           1
`define PLL_POWER_LO           0
`define PFD_POLARITY_BIT       7
`define CAL_REQUEST_BIT        0
`define VCO_DIV_HI             2
`define VCO_DIV_LO             0
`define DIV_BYPASS_BIT         0
`define VCO_SELECT_BIT         1
`define UPDATE_BIT             0

// field values
`define PLL_POWER_NORMAL       2'h0
`define PLL_POWER_DOWN_ASYNC   2'h1
`define VCO_DIV_CODE_MAX       3'h4
`define VCO_DIV_RATIO_BASE     3'h2

// reset values
`define RST_PLL_POWER_POLARITY 8'h01
`define RST_VCO_CALIBRATION    8'h00
`define RST_VCO_DIVIDER        8'h02
`define RST_DIST_SOURCE        8'h00

// calibration length in pclk cycles
`define CAL_CYCLES_DEFAULT     1000
`define CAL_COUNT_W            16

`endif

// file: clock_source_pll_config_pkg.sv
// types shared by the clock source configuration block
// assumes the params header is on the include path
`include "clock_source_pll_config_params.svh"

package clock_source_pll_config_pkg;

    // settings that drive the analog clock path
    typedef struct packed {
        logic       pll_enable;
        logic       pll_powerdown_async;
        logic       pfd_negative;
        logic [2:0] divider_ratio;
        logic       divider_bypass;
        logic       vco_select;
    } clock_path_cfg_t;

    // calibration handshake toward the vco
    typedef struct packed {
        logic start;
        logic reset;
        logic busy;
    } vco_cal_ctrl_t;

    typedef enum logic [1:0] {
        cal_idle,
        cal_running,
        cal_done
    } cal_state_t;

endpackage : clock_source_pll_config_pkg

// file: clock_source_pll_config.sv
// staged configuration of pll power, pfd polarity, vco divider and distribution source
// assumes an apb master on pclk and analog clock path logic reading the struct outputs
//
// Summary of operation
// - power field 01 powers down, 00 runs
// - bypass bit 1 skips the vco divider
// - source bit 0 clk pin, 1 internal vco
// - polarity bit 1 negative, 0 positive
// - polarity applies only with external vco
// - staged values take effect on update write
// - calibrate bit plus update starts calibration
// - divider code selects ratio two to six
// - reset values: pll off, divide four, clk
// - calibrate cleared then update resets calibration
//
// Decided for this implementation: the APB slave port.
`include "clock_source_pll_config_params.svh"

module clock_source_pll_config #(
    parameter int CAL_CYCLES = `CAL_CYCLES_DEFAULT
) (
    input  wire logic                                     pclk,
    input  wire logic                                     presetn,
    input  wire logic                                     psel,
    input  wire logic                                     penable,
    input  wire logic                                     pwrite,
    input  wire logic [`ADDR_W-1:0]                       paddr,
    input  wire logic [31:0]                              pwdata,
    output logic      [31:0]                              prdata,
    output logic                                          pready,
    output logic                                          pslverr,
    output clock_source_pll_config_pkg::clock_path_cfg_t  clk_path,
    output clock_source_pll_config_pkg::vco_cal_ctrl_t    vco_cal
);

    localparam logic [`CAL_COUNT_W-1:0] CAL_LAST = (`CAL_COUNT_W)'(CAL_CYCLES - 1);

    generate
        if (CAL_CYCLES < 1 || CAL_CYCLES > 65536) begin : g_bad_cal
            $error("CAL_CYCLES out of range");
        end
    endgenerate

    // staged copies written by software
    logic [7:0] staged_power;
    logic [7:0] staged_cal;
    logic [7:0] staged_div;
    logic [7:0] staged_src;
    logic       update_pending;

    // active copies used by the clock path
    logic [7:0] active_power;
    logic [7:0] active_cal;
    logic [7:0] active_div;
    logic [7:0] active_src;

    clock_source_pll_config_pkg::cal_state_t cal_state;
    logic [`CAL_COUNT_W-1:0]                 cal_count;

    // decode
    wire                      setup_phase = psel & ~penable;
    wire                      write_done  = psel & penable & pwrite & pready;
    wire                      aligned     = (paddr[1:0] == 2'h0);
    wire [`ADDR_W-3:0]        reg_idx     = paddr[`ADDR_W-1:2];
    wire                      hit_power   = aligned & (reg_idx == `IDX_PLL_POWER_POLARITY);
    wire                      hit_cal     = aligned & (reg_idx == `IDX_VCO_CALIBRATION);
    wire                      hit_div     = aligned & (reg_idx == `IDX_VCO_DIVIDER);
    wire                      hit_src     = aligned & (reg_idx == `IDX_DIST_SOURCE);
    wire                      hit_update  = aligned & (reg_idx == `IDX_STAGED_UPDATE);
    wire                      hit_status  = aligned & (reg_idx == `IDX_CONFIG_STATUS);
    wire                      hit_any     = hit_power | hit_cal | hit_div | hit_src
                                            | hit_update | hit_status;
    wire                      wr_power    = write_done & hit_power;
    wire                      wr_cal      = write_done & hit_cal;
    wire                      wr_div      = write_done & hit_div;
    wire                      wr_src      = write_done & hit_src;
    wire                      wr_update   = write_done & hit_update & pwdata[`UPDATE_BIT];

    // calibration edges decided at transfer time
    wire staged_cal_req = staged_cal[`CAL_REQUEST_BIT];
    wire active_cal_req = active_cal[`CAL_REQUEST_BIT];
    wire cal_kick       = update_pending & staged_cal_req & ~active_cal_req;
    wire cal_clear      = update_pending & ~staged_cal_req & active_cal_req;

    // status word shows active state and calibration progress
    wire [7:0] status_word = {3'h0,
                              clk_path.pll_enable,
                              active_cal_req,
                              (cal_state == clock_source_pll_config_pkg::cal_done),
                              (cal_state == clock_source_pll_config_pkg::cal_running),
                              update_pending};

    wire [7:0] read_byte = hit_power  ? staged_power :
                           hit_cal    ? staged_cal   :
                           hit_div    ? staged_div   :
                           hit_src    ? staged_src   :
                           hit_update ? {7'h0, update_pending} :
                           hit_status ? status_word  : 8'h00;

    // active field decode
    wire [1:0] power_field = active_power[`PLL_POWER_HI:`PLL_POWER_LO];
    wire       vco_sel     = active_src[`VCO_SELECT_BIT];
    wire [2:0] div_code    = active_div[`VCO_DIV_HI:`VCO_DIV_LO];
    // codes above the top ratio saturate rather than stop the divider
    wire [2:0] div_code_ok = (div_code > `VCO_DIV_CODE_MAX) ? `VCO_DIV_CODE_MAX : div_code;

    clock_source_pll_config_pkg::clock_path_cfg_t next_clk_path;

    always_comb begin
        next_clk_path                     = '0;
        next_clk_path.pll_enable          = (power_field == `PLL_POWER_NORMAL);
        next_clk_path.pll_powerdown_async = (power_field == `PLL_POWER_DOWN_ASYNC);
        // internal vco ignores the polarity bit
        next_clk_path.pfd_negative        = active_power[`PFD_POLARITY_BIT]
                                            & ~vco_sel;
        next_clk_path.divider_ratio       = div_code_ok + `VCO_DIV_RATIO_BASE;
        next_clk_path.divider_bypass      = active_src[`DIV_BYPASS_BIT];
        next_clk_path.vco_select          = vco_sel;
    end

    // apb answer: ready in the first access cycle, error on unmapped or unaligned
    wire        next_pready  = setup_phase;
    wire        next_pslverr = setup_phase & ~hit_any;
    wire [31:0] next_prdata  = (setup_phase & ~pwrite) ? {24'h00_0000, read_byte}
                                                       : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= next_pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // staged registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            staged_power <= `RST_PLL_POWER_POLARITY;
        end else if (wr_power) begin
            staged_power <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            staged_cal <= `RST_VCO_CALIBRATION;
        end else if (wr_cal) begin
            staged_cal <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            staged_div <= `RST_VCO_DIVIDER;
        end else if (wr_div) begin
            staged_div <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            staged_src <= `RST_DIST_SOURCE;
        end else if (wr_src) begin
            staged_src <= pwdata[7:0];
        end
    end

    // a new update write wins over the self clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_pending <= 1'b0;
        end else if (wr_update) begin
            update_pending <= 1'b1;
        end else if (update_pending) begin
            update_pending <= 1'b0;
        end
    end

    // transfer staged to active, one cycle after the update write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_power <= `RST_PLL_POWER_POLARITY;
        end else if (update_pending) begin
            active_power <= staged_power;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_cal <= `RST_VCO_CALIBRATION;
        end else if (update_pending) begin
            active_cal <= staged_cal;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_div <= `RST_VCO_DIVIDER;
        end else if (update_pending) begin
            active_div <= staged_div;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_src <= `RST_DIST_SOURCE;
        end else if (update_pending) begin
            active_src <= staged_src;
        end
    end

    // outputs to the clock path, one cycle behind the active copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_path <= '0;
        end else begin
            clk_path <= next_clk_path;
        end
    end

    // calibration sequencer; a second start needs a calibration reset first
    clock_source_pll_config_pkg::cal_state_t    next_cal_state;
    clock_source_pll_config_pkg::vco_cal_ctrl_t next_vco_cal;
    wire                                        cal_at_end     = (cal_count == CAL_LAST);
    // counter moves only while running, so every start counts from zero
    wire [`CAL_COUNT_W-1:0]                     next_cal_count =
        (cal_state == clock_source_pll_config_pkg::cal_running) ? cal_count + 1'b1 : '0;

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            clock_source_pll_config_pkg::cal_idle: begin
                if (cal_kick) begin
                    next_cal_state = clock_source_pll_config_pkg::cal_running;
                end
            end
            clock_source_pll_config_pkg::cal_running: begin
                if (cal_clear) begin
                    next_cal_state = clock_source_pll_config_pkg::cal_idle;
                end else if (cal_at_end) begin
                    next_cal_state = clock_source_pll_config_pkg::cal_done;
                end
            end
            clock_source_pll_config_pkg::cal_done: begin
                if (cal_clear) begin
                    next_cal_state = clock_source_pll_config_pkg::cal_idle;
                end
            end
            default: begin
                next_cal_state = clock_source_pll_config_pkg::cal_idle;
            end
        endcase
    end

    always_comb begin
        next_vco_cal       = '0;
        next_vco_cal.start = cal_kick;
        next_vco_cal.reset = cal_clear;
        next_vco_cal.busy  = (next_cal_state == clock_source_pll_config_pkg::cal_running);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state <= clock_source_pll_config_pkg::cal_idle;
            cal_count <= '0;
        end else begin
            cal_state <= next_cal_state;
            cal_count <= next_cal_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_cal <= '0;
        end else begin
            vco_cal <= next_vco_cal;
        end
    end

endmodule : clock_source_pll_config

// file: clock_source_pll_config_chk.sv
// port assertions of the clock source configuration block
// assumes a bind onto clock_source_pll_config, one pclk domain
`include "clock_source_pll_config_params.svh"

module clock_source_pll_config_chk #(
    parameter int CAL_CYCLES = `CAL_CYCLES_DEFAULT
) (
    input logic                                         pclk,
    input logic                                         presetn,
    input logic                                         psel,
    input logic                                         penable,
    input logic                                         pwrite,
    input logic [`ADDR_W-1:0]                           paddr,
    input logic [31:0]                                  pwdata,
    input logic [31:0]                                  prdata,
    input logic                                         pready,
    input logic                                         pslverr,
    input clock_source_pll_config_pkg::clock_path_cfg_t clk_path,
    input clock_source_pll_config_pkg::vco_cal_ctrl_t   vco_cal
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire upd = psel && penable && pready && pwrite && paddr == 14'h8c8 && pwdata[0];

    AST_PREADY_ONCE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    AST_ERR_ALIGN: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access without error");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_STAGED_ONLY: assert property (!$stable(clk_path) && $past(presetn, 2) |->
        $past(upd, 2) || $past(upd, 3) || $past(upd, 4)) else $error("path moved without update");
    AST_POWER_EXCL: assert property (!(clk_path.pll_enable && clk_path.pll_powerdown_async))
        else $error("pll both on and down");
    AST_PFD_GATED: assert property (clk_path.vco_select |-> !clk_path.pfd_negative)
        else $error("polarity applied with internal vco");
    AST_RATIO_RANGE: assert property ($past(presetn) |-> clk_path.divider_ratio inside {[2:6]})
        else $error("divider ratio out of range");
    AST_START_CAUSE: assert property ($rose(vco_cal.start) |-> $past(upd, 2) || $past(upd, 3))
        else $error("calibration start without update");
    AST_START_BUSY: assert property (vco_cal.start |-> ##[0:1] vco_cal.busy ##1 !vco_cal.start)
        else $error("start pulse malformed");
    AST_CAL_RESET_CAUSE: assert property ($rose(vco_cal.reset) |-> $past(upd, 2) || $past(upd, 3))
        else $error("calibration reset without update");
endmodule : clock_source_pll_config_chk

bind clock_source_pll_config clock_source_pll_config_chk #(.CAL_CYCLES(CAL_CYCLES)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_path(clk_path), .vco_cal(vco_cal));

// file: clock_source_pll_config_host.sv
// apb host model issuing register transfers
// assumes one transfer at a time, called from the bench top
module clock_source_pll_config_host (
    input  logic        pclk,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [13:0] paddr,
    output logic [31:0] pwdata,
    input  logic [31:0] prdata,
    input  logic        pready,
    input  logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    task xfer(input logic w, input logic [13:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // waits any number of cycles for pready; only the bench timeout ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task update;
        logic [31:0] r;
        logic        e;
        xfer(1'b1, 14'h8c8, 32'h1, r, e);
    endtask : update
endmodule : clock_source_pll_config_host

// file: clock_source_pll_config_test.sv
// self-checking bench of the clock source configuration block
// assumes the host model and checker files are compiled first
module clock_source_pll_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    clock_source_pll_config_pkg::clock_path_cfg_t clk_path;
    clock_source_pll_config_pkg::vco_cal_ctrl_t   vco_cal;
    int mismatches = 0, checks = 0, cycles = 0, starts = 0, resets = 0, busies = 0;

    clock_source_pll_config #(.CAL_CYCLES(8)) clock_source_pll_config_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_path(clk_path), .vco_cal(vco_cal));
    clock_source_pll_config_host clock_source_pll_config_host_i (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (vco_cal.start === 1'b1) starts++;
        if (vco_cal.reset === 1'b1) resets++;
        if (vco_cal.busy === 1'b1) busies++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test;
        end
    end

    task stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] e, input logic [31:0] g, input string n);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task wr(input logic [13:0] a, input logic [31:0] d);
        clock_source_pll_config_host_i.xfer(1'b1, a, d, rd, err);
    endtask : wr

    task rdc(input logic [13:0] a, input logic [31:0] e, input string n);
        clock_source_pll_config_host_i.xfer(1'b0, a, 32'h0, rd, err);
        chk(e, rd, n);
    endtask : rdc

    // power, polarity, ratio, bypass, source as the path should show them
    function automatic logic [7:0] exp_path(logic [7:0] pw, logic [7:0] sr, logic [7:0] dv);
        logic [2:0] ratio;
        ratio = (dv[2:0] > 3'h4) ? 3'h6 : dv[2:0] + 3'h2;
        return {pw[1:0] == 2'h0, pw[1:0] == 2'h1, pw[7] & ~sr[1], ratio, sr[0], sr[1]};
    endfunction : exp_path

    task cfg(input logic [7:0] pw, input logic [7:0] sr, input logic [7:0] dv);
        logic [7:0] held;
        held = clk_path;
        wr(14'h040, {24'h0, pw});
        wr(14'h784, {24'h0, sr});
        wr(14'h780, {24'h0, dv});
        wr(14'h8c8, 32'h0);
        repeat (3) @(posedge pclk);
        #1 chk({24'h0, held}, {24'h0, clk_path}, "staged path");
        clock_source_pll_config_host_i.update;
        repeat (3) @(posedge pclk);
        #1 chk({24'h0, exp_path(pw, sr, dv)}, {24'h0, clk_path}, "clk_path");
        rdc(14'h8c8, 32'h0, "update bit");
    endtask : cfg

    task cal(input logic [31:0] v);
        wr(14'h060, v);
        clock_source_pll_config_host_i.update;
        repeat (20) @(posedge pclk);
    endtask : cal

    initial begin
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 chk(32'h50, {24'h0, clk_path}, "reset path");
        rdc(14'h040, 32'h01, "power reg");
        rdc(14'h060, 32'h00, "cal reg");
        rdc(14'h780, 32'h02, "divider reg");
        rdc(14'h784, 32'h00, "source reg");
        cfg(8'h80, 8'h00, 8'h02);
        cfg(8'h01, 8'h01, 8'h02);
        cfg(8'h82, 8'h00, 8'h07);
        for (int c = 0; c < 5; c++) cfg(8'h80, 8'h02, c[7:0]);
        cal(32'h1);
        chk(32'h1, starts, "first start");
        chk(32'h8, busies, "busy length");
        rdc(14'h8cc, 32'h1c, "status done");
        cal(32'h1);
        chk(32'h1, starts, "no restart");
        cal(32'h0);
        chk(32'h1, resets, "cal reset");
        rdc(14'h8cc, 32'h10, "status reset");
        cal(32'h1);
        chk(32'h2, starts, "second start");
        clock_source_pll_config_host_i.xfer(1'b0, 14'h7fc, 32'h0, rd, err);
        chk(32'h1, {31'h0, err}, "unmapped error");
        chk(32'h0, rd, "unmapped data");
        clock_source_pll_config_host_i.xfer(1'b1, 14'h041, 32'h3, rd, err);
        chk(32'h1, {31'h0, err}, "misaligned error");
        rdc(14'h040, 32'h80, "power kept");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 chk(32'h50, {24'h0, clk_path}, "second reset path");
        rdc(14'h040, 32'h01, "power after reset");
        stop_test;
    end
endmodule : clock_source_pll_config_test
